// File: rtl/pmic_cfg_consts.vh
// constants for the switch, regulator and bus-option register bank
`ifndef PMIC_CFG_CONSTS_VH
`define PMIC_CFG_CONSTS_VH
`define ADDR_BUS_OPTIONS 8'h13
`define ADDR_WRITE_LOCK 8'h14
`define ADDR_LINEAR_REG 8'h36
`define ADDR_SWITCH_ONE 8'h69
`define ADDR_SWITCH_TWO 8'h6A
`define ADDR_SWITCH_THREE 8'h6B
`define RST_BUS_OPTIONS 8'h00
`define RST_WRITE_LOCK 8'h01
`define RST_LINEAR_REG 8'hA8
`define RST_SWITCH_ONE 8'h0D
`define RST_SWITCH_TWO 8'h25
`define RST_SWITCH_THREE 8'h20
`define MASK_BUS_OPTIONS 8'h13
`define MASK_WRITE_LOCK 8'h01
`define MASK_SWITCH 8'h3F
`define MASK_SWITCH_THREE 8'h38
`define BIT_SRC_SYS 5
`define BIT_SEL_HI 4
`define BIT_SEL_LO 3
`define BIT_DISCHARGE 7
`define BIT_PAIRED 4
`define BIT_TIMEOUT 1
`define BIT_FAST 0
`define BIT_LOCK 0
`define SRC_CONV_ONE 2'h0
`define SRC_CONV_TWO 2'h1
`define SRC_CONV_THREE 2'h2
`define SRC_SYSTEM 2'h3
// target voltage in mV: base plus code times step
`define VOUT_BASE_MV 12'h320
`define VOUT_STEP_MV 12'h019
// gate-drive oscillator in units of 12.5 kHz, code 0 gives 1 unit
`define DRV_UNIT_BASE 8'h01
`define DRV_CODE_HI 2
`define DRV_CODE_LO 0
`define VOUT_CODE_HI 6
`define VOUT_CODE_LO 0
`endif

// File: rtl/pmic_switch_ldo_i2c_config.v
// register bank for load switches, linear regulator and bus options
// What this block does
// - bit 5 routes switch from system supply
// - source field picks converter one, two, three
// - drive frequency doubles per code from 12.5kHz
// - regulator target is 0.8V plus code times 25mV
// - discharge resistor only when enabled and regulator off
// - paired-burst bit selects pair or sequential writes
// - timeout bit enables bus watchdog
// - sticky fast mode holds through stop
// - lock set discards all register writes except one that clears the lock
// - lock returns to locked at every stop
// - reset values come from factory options, except the write lock, which resets locked
`timescale 1ns/1ns
`include "pmic_cfg_consts.vh"
module pmic_switch_ldo_i2c_config #(
   parameter [7:0] OPT_BUS_OPTIONS = `RST_BUS_OPTIONS,
   parameter [7:0] OPT_LINEAR_REG = `RST_LINEAR_REG,
   parameter [7:0] OPT_SWITCH_ONE = `RST_SWITCH_ONE,
   parameter [7:0] OPT_SWITCH_TWO = `RST_SWITCH_TWO,
   parameter [7:0] OPT_SWITCH_THREE = `RST_SWITCH_THREE
) (
   input wire clk_i,
   input wire srst_i,
   input wire wr_en_i,
   input wire [7:0] wr_addr_i,
   input wire [7:0] wr_data_i,
   input wire [7:0] rd_addr_i,
   input wire stop_i,
   input wire linear_reg_enabled_i,
   output reg [7:0] rd_data_o,
   output reg [1:0] switch_one_source_o,
   output reg [1:0] switch_two_source_o,
   output reg [1:0] switch_three_source_o,
   output reg [7:0] switch_one_drive_units_o,
   output reg [7:0] switch_two_drive_units_o,
   output reg [11:0] linear_reg_target_mv_o,
   output reg linear_reg_discharge_on_o,
   output reg paired_burst_o,
   output reg bus_timeout_enable_o,
   output reg sticky_fast_mode_o,
   output reg global_write_lock_o
);
   // only the first two switches carry a gate-drive field
   localparam NUM_SWITCHES = 3;
   localparam NUM_DRIVEN = 2;
   reg [7:0] bus_interface_options;
   reg [7:0] write_lock_control;
   reg [7:0] linear_reg_config;
   reg [7:0] switch_one_config;
   reg [7:0] switch_two_config;
   reg [7:0] switch_three_config;
   reg [7:0] next_rd_data;
   wire clears_lock;
   wire wr_ok;
   wire wr_bus_options;
   wire wr_write_lock;
   wire wr_linear_reg;
   wire wr_switch_one;
   wire wr_switch_two;
   wire wr_switch_three;
   wire [7:0] switch_cfg [0:NUM_SWITCHES-1];
   wire [1:0] next_source [0:NUM_SWITCHES-1];
   wire [7:0] next_drive_units [0:NUM_DRIVEN-1];
   wire [11:0] next_target_mv;
   wire next_discharge_on;
   genvar sw;

   // option parameters stand in for factory fuses; no write path reaches them
   assign clears_lock = (wr_addr_i == `ADDR_WRITE_LOCK) && !wr_data_i[`BIT_LOCK];
   assign wr_ok = wr_en_i && (!write_lock_control[`BIT_LOCK] || clears_lock);
   // the lock check sits in the per-register enable decode
   assign wr_bus_options = wr_ok && (wr_addr_i == `ADDR_BUS_OPTIONS);
   assign wr_write_lock = wr_ok && (wr_addr_i == `ADDR_WRITE_LOCK);
   assign wr_linear_reg = wr_ok && (wr_addr_i == `ADDR_LINEAR_REG);
   assign wr_switch_one = wr_ok && (wr_addr_i == `ADDR_SWITCH_ONE);
   assign wr_switch_two = wr_ok && (wr_addr_i == `ADDR_SWITCH_TWO);
   assign wr_switch_three = wr_ok && (wr_addr_i == `ADDR_SWITCH_THREE);

   function [1:0] source_of;
      input [7:0] cfg;
      begin
         if (cfg[`BIT_SRC_SYS]) begin
            source_of = `SRC_SYSTEM;
         end else if (cfg[`BIT_SEL_HI]) begin
            source_of = `SRC_CONV_THREE;
         end else if (cfg[`BIT_SEL_LO]) begin
            source_of = `SRC_CONV_TWO;
         end else begin
            source_of = `SRC_CONV_ONE;
         end
      end
   endfunction

   assign switch_cfg[0] = switch_one_config;
   assign switch_cfg[1] = switch_two_config;
   assign switch_cfg[2] = switch_three_config;

   // one decode per switch; the third has no drive field to decode
   generate
      for (sw = 0; sw < NUM_SWITCHES; sw = sw + 1) begin : g_switch
         assign next_source[sw] = source_of(switch_cfg[sw]);
         if (sw < NUM_DRIVEN) begin : g_drive
            assign next_drive_units[sw] = `DRV_UNIT_BASE
               << switch_cfg[sw][`DRV_CODE_HI:`DRV_CODE_LO];
         end
      end
   endgenerate

   // top code gives 3975 mV, which still fits twelve bits
   assign next_target_mv = `VOUT_BASE_MV
      + linear_reg_config[`VOUT_CODE_HI:`VOUT_CODE_LO] * `VOUT_STEP_MV;
   assign next_discharge_on = linear_reg_config[`BIT_DISCHARGE] && !linear_reg_enabled_i;

   // unused bits are not stored, so host junk there is harmless
   always @(posedge clk_i) begin
      if (srst_i) begin
         bus_interface_options <= OPT_BUS_OPTIONS & `MASK_BUS_OPTIONS;
      end else if (wr_bus_options) begin
         bus_interface_options <= wr_data_i & `MASK_BUS_OPTIONS;
      end
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         linear_reg_config <= OPT_LINEAR_REG;
      end else if (wr_linear_reg) begin
         linear_reg_config <= wr_data_i;
      end
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         switch_one_config <= OPT_SWITCH_ONE & `MASK_SWITCH;
      end else if (wr_switch_one) begin
         switch_one_config <= wr_data_i & `MASK_SWITCH;
      end
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         switch_two_config <= OPT_SWITCH_TWO & `MASK_SWITCH;
      end else if (wr_switch_two) begin
         switch_two_config <= wr_data_i & `MASK_SWITCH;
      end
   end

   // switch three keeps only its source bits
   always @(posedge clk_i) begin
      if (srst_i) begin
         switch_three_config <= OPT_SWITCH_THREE & `MASK_SWITCH_THREE;
      end else if (wr_switch_three) begin
         switch_three_config <= wr_data_i & `MASK_SWITCH_THREE;
      end
   end

   // stop wins over a same-cycle write so the lock never stays open
   always @(posedge clk_i) begin
      if (srst_i) begin
         write_lock_control <= `RST_WRITE_LOCK;
      end else if (stop_i) begin
         write_lock_control <= `RST_WRITE_LOCK;
      end else if (wr_write_lock) begin
         write_lock_control <= wr_data_i & `MASK_WRITE_LOCK;
      end
   end

   // unmapped addresses read as zero
   always @* begin
      case (rd_addr_i)
         `ADDR_BUS_OPTIONS: begin
            next_rd_data = bus_interface_options;
         end
         `ADDR_WRITE_LOCK: begin
            next_rd_data = write_lock_control;
         end
         `ADDR_LINEAR_REG: begin
            next_rd_data = linear_reg_config;
         end
         `ADDR_SWITCH_ONE: begin
            next_rd_data = switch_one_config;
         end
         `ADDR_SWITCH_TWO: begin
            next_rd_data = switch_two_config;
         end
         `ADDR_SWITCH_THREE: begin
            next_rd_data = switch_three_config;
         end
         default: begin
            next_rd_data = 8'h00;
         end
      endcase
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         rd_data_o <= 8'h00;
         switch_one_source_o <= `SRC_CONV_ONE;
         switch_two_source_o <= `SRC_CONV_ONE;
         switch_three_source_o <= `SRC_CONV_ONE;
         switch_one_drive_units_o <= `DRV_UNIT_BASE;
         switch_two_drive_units_o <= `DRV_UNIT_BASE;
         linear_reg_target_mv_o <= `VOUT_BASE_MV;
         linear_reg_discharge_on_o <= 1'b0;
         paired_burst_o <= 1'b0;
         bus_timeout_enable_o <= 1'b0;
         sticky_fast_mode_o <= 1'b0;
         global_write_lock_o <= 1'b1;
      end else begin
         rd_data_o <= next_rd_data;
         switch_one_source_o <= next_source[0];
         switch_two_source_o <= next_source[1];
         switch_three_source_o <= next_source[2];
         switch_one_drive_units_o <= next_drive_units[0];
         switch_two_drive_units_o <= next_drive_units[1];
         linear_reg_target_mv_o <= next_target_mv;
         linear_reg_discharge_on_o <= next_discharge_on;
         paired_burst_o <= bus_interface_options[`BIT_PAIRED];
         bus_timeout_enable_o <= bus_interface_options[`BIT_TIMEOUT];
         // a stop does not touch this bit, so the mode survives it
         sticky_fast_mode_o <= bus_interface_options[`BIT_FAST];
         global_write_lock_o <= write_lock_control[`BIT_LOCK];
      end
   end
endmodule

// File: verif/pmic_cfg_host.sv
// host-side model of the bus core feeding the register port
`timescale 1ns/1ns
module pmic_cfg_host (
   input wire clk_i,
   output logic wr_en_o,
   output logic [7:0] wr_addr_o,
   output logic [7:0] wr_data_o,
   output logic [7:0] rd_addr_o,
   output logic stop_o
);
   initial {wr_en_o, wr_addr_o, wr_data_o, rd_addr_o, stop_o} = '0;
   // strobe stays high over back-to-back bytes, as a burst would give
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i) {wr_en_o, wr_addr_o, wr_data_o} = {1'b1, a, d};
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk_i) rd_addr_o = a;
      @(negedge clk_i);
   endtask
   // released data is scrambled so a stale byte cannot pass as valid
   task automatic idle(input logic s);
      @(negedge clk_i) {wr_en_o, stop_o, wr_data_o} = {1'b0, s, ~wr_data_o};
      @(negedge clk_i) stop_o = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask
endmodule

// File: verif/pmic_switch_ldo_i2c_config_sva.sv
// timing checks on the configuration register bank ports
`timescale 1ns/1ns
module pmic_cfg_sva (
   input wire clk_i,
   input wire srst_i,
   input wire wr_en_i,
   input wire [7:0] wr_addr_i,
   input wire [7:0] wr_data_i,
   input wire [7:0] rd_addr_i,
   input wire stop_i,
   input wire linear_reg_enabled_i,
   input wire [7:0] rd_data_o,
   input wire [1:0] switch_three_source_o,
   input wire [7:0] switch_one_drive_units_o,
   input wire [11:0] linear_reg_target_mv_o,
   input wire linear_reg_discharge_on_o,
   input wire paired_burst_o,
   input wire bus_timeout_enable_o,
   input wire sticky_fast_mode_o,
   input wire global_write_lock_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   a_lock_at_stop: assert property (stop_i |-> ##2 global_write_lock_o)
      else $error("lock not restored after stop");
   a_lock_clear: assert property (
      wr_en_i && wr_addr_i == 8'h14 && !wr_data_i[0] && !stop_i |-> ##2 !global_write_lock_o)
      else $error("lock clear refused");
   a_voltage_code: assert property (
      (wr_en_i && wr_addr_i == 8'h14 && wr_data_i == 8'h00 && !stop_i)
      ##1 (wr_en_i && wr_addr_i == 8'h36)
      |-> ##2 linear_reg_target_mv_o == 12'h320 + 12'h019 * $past(wr_data_i[6:0], 2))
      else $error("bad target");
   a_discharge_off: assert property (
      linear_reg_discharge_on_o |-> !$past(linear_reg_enabled_i))
      else $error("discharge while enabled");
   a_drive_onehot: assert property ($onehot(switch_one_drive_units_o))
      else $error("drive not a power of two");
   a_hold_nowrite: assert property (
      (!wr_en_i)[*4] |-> $stable({switch_three_source_o, paired_burst_o, sticky_fast_mode_o}))
      else $error("config moved");
   a_read_lock: assert property (
      !$past(srst_i) && $past(rd_addr_i) == 8'h14 |-> rd_data_o == {7'h00, global_write_lock_o})
      else $error("lock readback");
   a_read_opts: assert property (
      !$past(srst_i) && $past(rd_addr_i) == 8'h13 |-> rd_data_o
      == {3'h0, paired_burst_o, 2'h0, bus_timeout_enable_o, sticky_fast_mode_o})
      else $error("option readback");
   c_stop: cover property (stop_i);
   c_unlock: cover property (wr_en_i && wr_addr_i == 8'h14 && !wr_data_i[0]);
   c_discharge: cover property (linear_reg_discharge_on_o);
endmodule
bind pmic_switch_ldo_i2c_config pmic_cfg_sva chk (.*);

// File: verif/tb_pmic_switch_ldo_i2c_config.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ns
module tb_pmic_switch_ldo_i2c_config;
   logic clk_i = 0, srst_i = 1, lre = 0;
   wire we, st, dis, pb, bt, sf, lk;
   wire [7:0] wa, wd, ra, rdat, u1, u2;
   wire [1:0] s1, s2, s3;
   wire [11:0] mv;
   int n_errors = 0, checks = 0;
   logic [7:0] adr [7] = '{8'h13, 8'h14, 8'h36, 8'h69, 8'h6A, 8'h6B, 8'h00};
   logic [7:0] rst [7] = '{8'h00, 8'h01, 8'hA8, 8'h0D, 8'h25, 8'h20, 8'h00};
   initial forever #10 clk_i = ~clk_i;
   pmic_cfg_host h (.clk_i(clk_i), .wr_en_o(we), .wr_addr_o(wa), .wr_data_o(wd),
      .rd_addr_o(ra), .stop_o(st));
   pmic_switch_ldo_i2c_config dut (.clk_i(clk_i), .srst_i(srst_i), .wr_en_i(we),
      .wr_addr_i(wa), .wr_data_i(wd), .rd_addr_i(ra), .stop_i(st), .linear_reg_enabled_i(lre),
      .rd_data_o(rdat), .switch_one_source_o(s1), .switch_two_source_o(s2),
      .switch_three_source_o(s3), .switch_one_drive_units_o(u1), .switch_two_drive_units_o(u2),
      .linear_reg_target_mv_o(mv), .linear_reg_discharge_on_o(dis), .paired_burst_o(pb),
      .bus_timeout_enable_o(bt), .sticky_fast_mode_o(sf), .global_write_lock_o(lk));
   task automatic chk(input logic [11:0] g, input logic [11:0] e);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      h.rd(a);
      chk({4'h0, rdat}, {4'h0, e});
   endtask
   task automatic results;
      if (n_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // whole run is about 80 cycles; this leaves wide margin
   initial begin
      #100000;
      n_errors++;
      results();
   end
   initial begin
      repeat (12) @(negedge clk_i);
      srst_i = 0;
      for (int i = 0; i < 7; i++) rdc(adr[i], rst[i]);
      chk({10'h0, s3}, 12'h003);
      h.wr(8'h36, 8'h05);
      h.idle(0);
      rdc(8'h36, 8'hA8);
      h.wr(8'h14, 8'h00);
      h.wr(8'h36, 8'h7F);
      h.wr(8'h13, 8'h13);
      h.wr(8'h69, 8'h3F);
      h.idle(1);
      chk(mv, 12'hF87);
      chk({4'h0, u1}, 12'h080);
      chk({10'h0, s1}, 12'h003);
      chk({9'h0, pb, bt, sf}, 12'h007);
      chk({11'h0, lk}, 12'h001);
      h.wr(8'h14, 8'h00);
      for (int i = 0; i < 4; i++) begin
         h.wr(8'h6A, 8'(i << 3));
         h.idle(0);
         chk({10'h0, s2}, (i > 1) ? 12'h002 : 12'(i));
      end
      chk({4'h0, u2}, 12'h001);
      h.wr(8'h36, 8'h80);
      h.idle(0);
      chk({11'h0, dis}, 12'h001);
      lre = 1;
      h.idle(1);
      chk({11'h0, dis}, 12'h000);
      h.wr(8'h69, 8'h00);
      h.idle(0);
      chk({10'h0, s1}, 12'h003);
      // second reset in mid-run must bring back the option values
      srst_i = 1;
      lre = 0;
      repeat (2) @(negedge clk_i);
      srst_i = 0;
      rdc(8'h69, 8'h0D);
      chk({11'h0, dis}, 12'h001);
      chk({11'h0, lk}, 12'h001);
      results();
   end
endmodule
